// [shared/dsp_pkg.sv]
// Constants and types for the nonvolatile data store controller.
// Assumes a single core clock domain and an SFR-style register port.
package dsp_pkg;
   localparam logic [7:0] DSP_ADDR_OFS = 8'hC6;
   localparam logic [7:0] DSP_CTRL_OFS = 8'hCE;
   localparam logic [7:0] DSP_DATA_OFS = 8'hCF;
   localparam int DSP_ERASE_BIT = 7;
   localparam int DSP_WRITE_BIT = 6;
   localparam logic [7:0] DSP_ADDR_RST = 8'h00;
   localparam logic [7:0] DSP_DATA_RST = 8'h00;
   localparam logic [7:0] DSP_ERASED = 8'hFF;
   localparam int DSP_PAGES = 4;
   localparam int DSP_PAGE_BYTES = 64;
   localparam int DSP_BYTES = DSP_PAGES * DSP_PAGE_BYTES;
   // Programming times, in ns, and derived cycle counts at 125 MHz
   localparam int DSP_CLK_NS = 8;
   localparam int DSP_ERASE_NS = 800;
   localparam int DSP_WRITE_NS = 240;
   localparam int DSP_ERASE_CYC = (DSP_ERASE_NS + DSP_CLK_NS - 1) / DSP_CLK_NS;
   localparam int DSP_WRITE_CYC = (DSP_WRITE_NS + DSP_CLK_NS - 1) / DSP_CLK_NS;
   typedef enum logic [1:0] {DSP_IDLE, DSP_ERASE, DSP_WRITE} dsp_state_t;
endpackage

// [shared/dsp_mem_if.sv]
// Carrier between the controller and its storage array.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
interface dsp_mem_if;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic erase_en;
   logic [1:0] erase_page;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   modport ctrl (output wr_en, wr_addr, wr_data, erase_en, erase_page, rd_addr,
      input rd_data);
   modport mem (input wr_en, wr_addr, wr_data, erase_en, erase_page, rd_addr,
      output rd_data);
endinterface

// [rtl/dsp_array.sv]
// Storage array of the data store: four pages of 64 bytes.
// Assumes the controller issues one erase or write at a time.
`timescale 1ns/1ps
module dsp_array
   import dsp_pkg::*;
(
   // Clock
   input wire logic sys_clk,
   // Controller side
   dsp_mem_if.mem m
);
   // Power-up content is erased state; no reset since this models flash cells
   // Initialised at declaration so the cell processes stay the only writers
   logic [7:0] mem_r [DSP_BYTES] = '{default: DSP_ERASED};

   genvar g;
   generate
      for (g = 0; g < DSP_BYTES; g++) begin : g_cell
         always_ff @(posedge sys_clk) begin
            if (m.erase_en && m.erase_page == 2'(g / DSP_PAGE_BYTES)) begin
               mem_r[g] <= DSP_ERASED;
            end else if (m.wr_en && m.wr_addr == 8'(g)) begin
               mem_r[g] <= m.wr_data;
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      m.rd_data <= mem_r[m.rd_addr];
   end
endmodule

// [rtl/dsp_ctrl.sv]
// Data store controller on the core's special function register port.
// Assumes the core holds its program counter while core_stall is high.
`timescale 1ns/1ps
module dsp_ctrl
   import dsp_pkg::*;
#(
   parameter bit REDUCED = 1'b0
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Special function register port
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // Core handshake
   output logic core_stall,
   // Code read path
   input wire logic [7:0] code_addr,
   output logic [7:0] code_rdata
);
   import dsp_pkg::*;

   typedef struct packed {
      dsp_state_t st;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] ctrl;
      logic [9:0] cnt;
      logic stall;
      logic [7:0] rdata;
   } dsp_regs_t;

   dsp_regs_t s_r;
   dsp_regs_t s_nxt;
   dsp_mem_if mi ();

   logic [1:0] sel_page;
   logic page_ok;
   logic code_ok_r;

   // Page selection is the top two address bits
   assign sel_page = s_r.addr[7:6];
   // Missing pages in the reduced variant are never touched
   assign page_ok = !REDUCED || !sel_page[1];

   always_comb begin
      s_nxt = s_r;
      unique case (s_r.st)
         DSP_IDLE: begin
            if (sfr_wr) begin
               if (sfr_addr == DSP_ADDR_OFS) s_nxt.addr = sfr_wdata;
               if (sfr_addr == DSP_DATA_OFS) s_nxt.wdata = sfr_wdata;
               if (sfr_addr == DSP_CTRL_OFS) begin
                  // Only bits 7 and 6 are kept; reserved bits dropped
                  s_nxt.ctrl = {sfr_wdata[DSP_ERASE_BIT], sfr_wdata[DSP_WRITE_BIT],
                     6'h00};
                  if (sfr_wdata[DSP_ERASE_BIT]) begin
                     s_nxt.st = DSP_ERASE;
                     s_nxt.cnt = 10'(DSP_ERASE_CYC - 1);
                     s_nxt.stall = 1'b1;
                  end else if (sfr_wdata[DSP_WRITE_BIT]) begin
                     s_nxt.st = DSP_WRITE;
                     s_nxt.cnt = 10'(DSP_WRITE_CYC - 1);
                     s_nxt.stall = 1'b1;
                  end
               end
            end
         end
         DSP_ERASE, DSP_WRITE: begin
            if (s_r.cnt == 10'h000) begin
               s_nxt.st = DSP_IDLE;
               s_nxt.stall = 1'b0;
               s_nxt.ctrl = 8'h00;
            end else begin
               s_nxt.cnt = s_r.cnt - 10'h001;
            end
         end
         default: s_nxt.st = DSP_IDLE;
      endcase
      // Data register is write-only; reads give zero
      if (sfr_addr == DSP_ADDR_OFS) s_nxt.rdata = s_r.addr;
      else if (sfr_addr == DSP_CTRL_OFS) s_nxt.rdata = s_r.ctrl;
      else s_nxt.rdata = 8'h00;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_r <= '{st: DSP_IDLE, addr: DSP_ADDR_RST, wdata: DSP_DATA_RST, ctrl: 8'h00,
            cnt: 10'h000, stall: 1'b0, rdata: 8'h00};
         code_ok_r <= 1'b0;
      end else begin
         s_r <= s_nxt;
         code_ok_r <= !REDUCED || !code_addr[7];
      end
   end

   // Cells are committed in the last cycle of the timed operation
   assign mi.erase_en = s_r.st == DSP_ERASE && s_r.cnt == 10'h000 && page_ok;
   assign mi.erase_page = sel_page;
   assign mi.wr_en = s_r.st == DSP_WRITE && s_r.cnt == 10'h000 && page_ok;
   assign mi.wr_addr = s_r.addr;
   assign mi.wr_data = s_r.wdata;
   assign mi.rd_addr = code_addr;

   dsp_array u_array (
      .sys_clk(sys_clk),
      .m(mi)
   );

   assign sfr_rdata = s_r.rdata;
   assign core_stall = s_r.stall;
   // Absent pages read as erased
   assign code_rdata = code_ok_r ? mi.rd_data : DSP_ERASED;

   a_erase_stall: assert property (@(posedge sys_clk) disable iff (rst)
      (sfr_wr && s_r.st == DSP_IDLE && sfr_addr == DSP_CTRL_OFS && sfr_wdata[7])
      |=> core_stall [*8])
      else $error("erase did not stall");
   a_erase_first: assert property (@(posedge sys_clk) disable iff (rst)
      (sfr_wr && s_r.st == DSP_IDLE && sfr_addr == DSP_CTRL_OFS && sfr_wdata[7])
      |=> s_r.st == DSP_ERASE)
      else $error("erase lost priority");
   a_write_stall: assert property (@(posedge sys_clk) disable iff (rst)
      (sfr_wr && s_r.st == DSP_IDLE && sfr_addr == DSP_CTRL_OFS && sfr_wdata[7:6] == 2'b01)
      |=> core_stall [*8] ##[1:40] !core_stall)
      else $error("write stall wrong");
   a_stall_end: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(core_stall) |-> $past(s_r.cnt) == 10'h000)
      else $error("stall released early");
   a_addr_load: assert property (@(posedge sys_clk) disable iff (rst)
      (sfr_wr && s_r.st == DSP_IDLE && sfr_addr == DSP_ADDR_OFS) |=> s_r.addr == $past(sfr_wdata))
      else $error("address not loaded");
   a_data_load: assert property (@(posedge sys_clk) disable iff (rst)
      (sfr_wr && s_r.st == DSP_IDLE && sfr_addr == DSP_DATA_OFS) |=> s_r.wdata == $past(sfr_wdata))
      else $error("data not loaded");
   a_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst)
      s_r.ctrl[5:0] == 6'h00)
      else $error("reserved bits stored");
   a_reduced_page: assert property (@(posedge sys_clk) disable iff (rst)
      (REDUCED && (mi.erase_en || mi.wr_en)) |-> !s_r.addr[7])
      else $error("absent page touched");
   a_page_sel: assert property (@(posedge sys_clk) disable iff (rst)
      mi.erase_en |-> mi.erase_page == s_r.addr[7:6])
      else $error("wrong erase page");
endmodule

// [verification/dsp_core_model.sv]
// Core model: register writes and code reads, halting while stalled.
// Assumes dsp_ctrl on sys_clk; drives 1 ns after each rising edge.
`timescale 1ns/1ps
module dsp_core_model (
   // Clock and handshake
   input wire logic sys_clk,
   input wire logic core_stall,
   // Register port and code read path
   output logic sfr_wr,
   output logic [7:0] sfr_addr,
   output logic [7:0] sfr_wdata,
   output logic [7:0] code_addr,
   input wire logic [7:0] sfr_rdata,
   input wire logic [7:0] code_rdata
);
   initial begin
      sfr_wr = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      code_addr = 8'h00;
   end
   // Returns how many cycles the core was held
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d, output int n);
      n = 0;
      @(posedge sys_clk) #1;
      sfr_wr = 1'b1;
      sfr_addr = a;
      sfr_wdata = d;
      @(posedge sys_clk) #1;
      sfr_wr = 1'b0;
      // Stale data must not pass for valid
      sfr_wdata = ~d;
      while (core_stall === 1'b1 && n < 300) begin
         n++;
         @(posedge sys_clk) #1;
      end
   endtask
   task automatic sfr_read(input logic [7:0] a, output logic [7:0] q);
      @(posedge sys_clk) #1;
      sfr_addr = a;
      @(posedge sys_clk) #1;
      q = sfr_rdata;
   endtask
   // Stored bytes come back only through the code path
   task automatic code_read(input logic [7:0] a, output logic [7:0] q);
      @(posedge sys_clk) #1;
      code_addr = a;
      @(posedge sys_clk) #1;
      q = code_rdata;
   endtask
endmodule

// [verification/testbench.sv]
// Self-checking bench for the data store controller.
// Assumes the default full variant with four pages.
`timescale 1ns/1ps
module testbench;
   import dsp_pkg::*;
   logic sys_clk, rst, sfr_wr, core_stall;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, code_addr, code_rdata, q;
   int err_count = 0;
   int n_compared = 0;
   int n;
   dsp_ctrl dsp_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .sfr_wr(sfr_wr),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .core_stall(core_stall), .code_addr(code_addr), .code_rdata(code_rdata));
   dsp_core_model dsp_core_model_inst (.sys_clk(sys_clk), .core_stall(core_stall),
      .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
      .code_addr(code_addr), .sfr_rdata(sfr_rdata), .code_rdata(code_rdata));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_cycles(input int got, input int exp);
      n_compared++;
      if (got != exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("compared=%0d errors=%0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input int exp_n);
      dsp_core_model_inst.sfr_write(a, d, n);
      check_cycles(n, exp_n);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      dsp_core_model_inst.sfr_read(a, q);
      check_byte(q, exp);
   endtask
   task automatic cr(input logic [7:0] a, input logic [7:0] exp);
      dsp_core_model_inst.code_read(a, q);
      check_byte(q, exp);
   endtask
   initial begin
      repeat (5000) @(posedge sys_clk);
      err_count++;
      give_verdict();
   end
   initial begin
      rst = 1'b1;
      repeat (10) @(posedge sys_clk);
      #1 rst = 1'b0;
      rd(DSP_ADDR_OFS, DSP_ADDR_RST);
      rd(DSP_CTRL_OFS, 8'h00);
      wr(DSP_ADDR_OFS, 8'h3F, 0);
      wr(DSP_DATA_OFS, 8'h12, 0);
      wr(DSP_CTRL_OFS, 8'h40, DSP_WRITE_CYC);
      rd(DSP_CTRL_OFS, 8'h00);
      wr(DSP_ADDR_OFS, 8'h40, 0);
      wr(DSP_DATA_OFS, 8'hA5, 0);
      wr(DSP_CTRL_OFS, 8'h40, DSP_WRITE_CYC);
      rd(DSP_DATA_OFS, 8'h00);
      cr(8'h3F, 8'h12);
      cr(8'h40, 8'hA5);
      // Reserved bits alone start nothing
      wr(DSP_CTRL_OFS, 8'h3F, 0);
      cr(8'h40, 8'hA5);
      wr(DSP_ADDR_OFS, 8'h7F, 0);
      wr(DSP_DATA_OFS, 8'h00, 0);
      wr(DSP_CTRL_OFS, 8'hFF, DSP_ERASE_CYC);
      cr(8'h40, DSP_ERASED);
      cr(8'h7F, DSP_ERASED);
      cr(8'h3F, 8'h12);
      rd(DSP_ADDR_OFS, 8'h7F);
      wr(DSP_ADDR_OFS, 8'hBF, 0);
      wr(DSP_DATA_OFS, 8'h66, 0);
      wr(DSP_CTRL_OFS, 8'h40, DSP_WRITE_CYC);
      wr(DSP_ADDR_OFS, 8'hC0, 0);
      wr(DSP_CTRL_OFS, 8'h40, DSP_WRITE_CYC);
      cr(8'hC0, 8'h66);
      wr(DSP_ADDR_OFS, 8'hC1, 0);
      wr(DSP_CTRL_OFS, 8'h80, DSP_ERASE_CYC);
      cr(8'hC0, DSP_ERASED);
      cr(8'hBF, 8'h66);
      give_verdict();
   end
endmodule
